/* File: src/rsq_pkg.sv */
// shared constants and types for the radio status query command block
package rsq_pkg;
  localparam logic [7:0] OP_READ_CHIP_STATE = 8'hc0;
  localparam logic [7:0] OP_READ_RX_BUFFER_INFO = 8'h13;
  localparam logic [7:0] OP_READ_PACKET_QUALITY = 8'h14;
  localparam logic [7:0] OP_READ_INSTANT_STRENGTH = 8'h15;
  localparam logic [7:0] OP_READ_PACKET_COUNTERS = 8'h10;
  localparam logic [7:0] OP_CLEAR_PACKET_COUNTERS = 8'h00;
  localparam logic [7:0] OP_READ_ERROR_FLAGS = 8'h17;
  localparam logic [7:0] OP_CLEAR_ERROR_FLAGS = 8'h07;
  // total frame length in bytes, opcode included
  localparam logic [3:0] LEN_CHIP_STATE = 4'h2;
  localparam logic [3:0] LEN_RX_BUFFER_INFO = 4'h4;
  localparam logic [3:0] LEN_PACKET_QUALITY = 4'h5;
  localparam logic [3:0] LEN_INSTANT_STRENGTH = 4'h3;
  localparam logic [3:0] LEN_PACKET_COUNTERS = 4'h8;
  localparam logic [3:0] LEN_CLEAR_PACKET_COUNTERS = 4'h7;
  localparam logic [3:0] LEN_READ_ERROR_FLAGS = 4'h4;
  localparam logic [3:0] LEN_CLEAR_ERROR_FLAGS = 4'h3;
  // command status codes, status bits 3:1
  localparam logic [2:0] CST_NONE = 3'h0;
  localparam logic [2:0] CST_DATA_AVAILABLE = 3'h2;
  localparam logic [2:0] CST_CMD_TIMEOUT = 3'h3;
  localparam logic [2:0] CST_PROCESSING_ERROR = 3'h4;
  localparam logic [2:0] CST_EXEC_FAILURE = 3'h5;
  localparam logic [2:0] CST_TX_DONE = 3'h6;
  localparam int STATUS_MODE_LSB = 4;
  localparam int STATUS_CMD_LSB = 1;
  localparam logic [15:0] ERROR_WORD_USED_MASK = 16'h017f;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  // longest allowed frame, counted in system cycles
  localparam int CMD_TIMEOUT_US = 1000;
  localparam int CLK_SYS_MHZ = 20;
  localparam int CMD_TIMEOUT_CYCLES = CMD_TIMEOUT_US * CLK_SYS_MHZ;

  typedef enum logic [2:0] {
    RSQ_MODE_UNUSED = 3'h0,
    RSQ_MODE_STANDBY_RC = 3'h2,
    RSQ_MODE_STANDBY_XOSC = 3'h3,
    RSQ_MODE_FS = 3'h4,
    RSQ_MODE_RX = 3'h5,
    RSQ_MODE_TX = 3'h6
  } rsq_mode_type;

  // per-packet measurements from the modem
  typedef struct packed {
    logic [7:0] last_payload_length;
    logic [7:0] payload_start_offset;
    logic [7:0] fsk_receive_flags;
    logic [7:0] sync_time_strength;
    logic [7:0] payload_average_strength;
    logic [7:0] chirp_packet_strength;
    logic [7:0] chirp_packet_snr;
    logic [7:0] despread_signal_strength;
  } rsq_packet_info_type;

  // one-cycle modem events
  typedef struct packed {
    logic packet_done;
    logic crc_fail;
    logic length_fail;
    logic header_fail;
    logic tx_done;
    logic exec_fail;
  } rsq_events_type;
endpackage : rsq_pkg

/* File: src/rsq_spi_link.sv */
// spi slave shifter on the link clock, byte handshake to the system domain
`timescale 1ns/1ps
`default_nettype none
module rsq_spi_link (
  // link side
  input wire logic spi_sck,
  input wire logic chip_select_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // frame control, link domain: reset while select is high
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic rx_toggle,
  output logic [2:0] bit_index
);
  logic [7:0] shift_reg;
  logic [7:0] out_reg;

  // mode 0: sample on rising edge, shift out on falling edge
  always_ff @(posedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_index <= 3'h0;
      shift_reg <= 8'h00;
      rx_byte <= 8'h00;
      rx_toggle <= 1'b0;
    end else begin
      bit_index <= bit_index + 3'h1;
      shift_reg <= {shift_reg[6:0], spi_mosi};
      if (bit_index == 3'h7) begin
        rx_byte <= {shift_reg[6:0], spi_mosi};
        rx_toggle <= ~rx_toggle;
      end
    end
  end

  // byte to host is loaded at the byte boundary; before the first edge it is the opcode slot
  always_ff @(negedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      out_reg <= 8'h00;
    end else if (bit_index == 3'h0) begin
      out_reg <= {tx_byte[6:0], 1'b0};
    end else begin
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end

  always_ff @(negedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      spi_miso <= 1'b0;
    end else if (bit_index == 3'h0) begin
      spi_miso <= tx_byte[7];
    end else begin
      spi_miso <= out_reg[7];
    end
  end
endmodule : rsq_spi_link
`default_nettype wire

/* File: src/rsq_status_query.sv */
// radio status and diagnostics query command interpreter
// Operation
// RL1: opcode c0 plus one nop returns the status byte in byte one.
// RL2: overlong frame fires a watchdog and reports command timeout; host may disable.
// RL3: unknown opcode or wrong byte count reports processing error.
// RL4: accepted command that cannot execute reports failure to execute.
// RL5: successful reception reports data available.
// RL6: end of transmission reports transmit done.
// RL7: opcode 13 returns status, payload length and payload start offset.
// RL8: start offset is relative to buffer start; works for every modem.
// RL9: opcode 14 returns status plus three packet-type dependent quality bytes.
// RL10: fsk receive flags byte carries eight error and done flags.
// RL11: sync-time strength is captured at sync detection, dBm is minus half.
// RL12: payload average strength captured at packet done, same encoding.
// RL13: chirp snr is a two's-complement byte scaled by four.
// RL14: chirp packet strength and despread strength, minus half dBm.
// RL15: opcode 15 with two nops returns status and instantaneous strength.
// RL16: opcode 10 returns three 16-bit counters, most significant byte first.
// RL17: opcode 00 plus six zero bytes clears all three counters.
// RL18: opcode 17 returns status then the 16-bit error word, msb first.
// RL19: error word bit meanings fixed; bits 7 and 15:9 reserved.
// RL20: opcode 07 with two zero bytes clears all error flags at once.
// RL21: every operation is an opcode byte plus parameters under low chip select.
// RL22: busy output shows the device is occupied.
// RL23: status byte holds mode in bits 6:4 and command status in 3:1.
// RL24: status byte is also returned while command bytes shift in.
// RL25: counters count receptions and crc or length/header failures.
`timescale 1ns/1ps
`default_nettype none
module rsq_status_query #(
  parameter int TIMEOUT_CYCLES = rsq_pkg::CMD_TIMEOUT_CYCLES
) (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // spi link, own clock
  input wire logic spi_sck,
  input wire logic chip_select_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic busy,
  // configuration and modem state
  input wire logic watchdog_enable,
  input wire logic chirp_packet_type,
  input wire rsq_pkg::rsq_mode_type chip_mode,
  input wire rsq_pkg::rsq_packet_info_type packet_info,
  input wire logic sync_detect,
  input wire logic [7:0] instant_strength,
  input wire rsq_pkg::rsq_events_type events,
  input wire logic [15:0] error_set,
  // status outputs
  output logic [15:0] device_error_word,
  output logic [2:0] command_status
);
  import rsq_pkg::*;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // link domain
  logic [7:0] tx_byte_reg;
  logic [7:0] rx_byte;
  logic rx_toggle;
  logic [2:0] bit_index;
  logic [3:0] link_count_reg;
  logic [7:0] link_opcode_reg;
  logic [7:0] status_byte;
  logic [7:0] status_sync1_reg;
  logic [7:0] status_sync2_reg;
  logic [7:0] resp_byte;

  rsq_spi_link u_link (
    .spi_sck(spi_sck),
    .chip_select_n(chip_select_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .tx_byte(tx_byte_reg),
    .rx_byte(rx_byte),
    .rx_toggle(rx_toggle),
    .bit_index(bit_index)
  );

  // snapshot of readable data, held in the system domain and frozen during a frame
  logic [63:0] snap_reg;
  logic [63:0] link_view;
  logic frame_sync_reg;

  // link-side byte counter and opcode capture
  always_ff @(posedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      link_count_reg <= 4'h0;
      link_opcode_reg <= 8'h00;
    end else begin
      if (bit_index == 3'h7 && link_count_reg != 4'hf) begin
        link_count_reg <= link_count_reg + 4'h1;
      end
      // rx_byte holds the opcode from the first edge of byte one on
      if (link_count_reg == 4'h1 && bit_index == 3'h0) begin
        link_opcode_reg <= rx_byte;
      end
    end
  end

  // status word crosses to the link clock through two flops; it changes slowly
  always_ff @(posedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      status_sync1_reg <= 8'h00;
      status_sync2_reg <= 8'h00;
    end else begin
      status_sync1_reg <= status_byte;
      status_sync2_reg <= status_sync1_reg;
    end
  end

  // views are frozen for the whole frame, so the link side reads them directly
  always_comb begin
    resp_byte = status_sync2_reg; // RL24
    unique case (link_opcode_reg)
      OP_READ_RX_BUFFER_INFO, OP_READ_PACKET_QUALITY, OP_READ_INSTANT_STRENGTH,
      OP_READ_PACKET_COUNTERS, OP_READ_ERROR_FLAGS: begin
        // loaded one byte ahead: count k feeds byte k + 1
        if (link_count_reg >= 4'h1 && link_count_reg <= 4'h6) begin
          resp_byte = link_view[63 - 8 * (link_count_reg - 4'h1) -: 8]; // RL7
        end
      end
      default: begin
        resp_byte = status_sync2_reg; // RL1
      end
    endcase
  end

  // byte 0 reads as zero and loads the status for slot 1; later bytes take resp for the next slot
  always_ff @(negedge spi_sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      tx_byte_reg <= 8'h00;
    end else if (bit_index == 3'h7) begin
      tx_byte_reg <= (link_count_reg == 4'h0) ? status_sync2_reg : resp_byte;
    end
  end

  // system domain: select and byte toggle synchronisers
  logic [1:0] cs_sync_reg;
  logic [2:0] tog_sync_reg;
  logic [7:0] rx_cap_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg <= 2'b11;
      tog_sync_reg <= 3'b000;
      rx_cap_reg <= 8'h00;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], chip_select_n};
      tog_sync_reg <= {tog_sync_reg[1:0], rx_toggle};
      rx_cap_reg <= rx_byte;
    end
  end
  logic frame_active;
  logic byte_event;
  logic frame_end;
  assign frame_active = ~cs_sync_reg[1];
  // rx_byte is stable well before the synchronised toggle is seen
  assign byte_event = tog_sync_reg[2] ^ tog_sync_reg[1];
  assign frame_end = frame_sync_reg & ~frame_active;

  logic [3:0] sys_count_reg;
  logic [7:0] opcode_reg;
  logic nonzero_param_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_sync_reg <= 1'b0;
      sys_count_reg <= 4'h0;
      opcode_reg <= 8'h00;
      nonzero_param_reg <= 1'b0;
    end else begin
      frame_sync_reg <= frame_active;
      if (frame_end) begin
        sys_count_reg <= 4'h0;
        nonzero_param_reg <= 1'b0;
      end else if (byte_event) begin
        if (sys_count_reg != 4'hf) begin
          sys_count_reg <= sys_count_reg + 4'h1;
        end
        if (sys_count_reg == 4'h0) begin
          opcode_reg <= rx_cap_reg;
        end else if (rx_cap_reg != 8'h00) begin
          nonzero_param_reg <= 1'b1;
        end
      end
    end
  end

  // frame check at end of select
  logic [3:0] expect_len;
  logic known_op;
  always_comb begin
    expect_len = 4'h0;
    known_op = 1'b1;
    unique case (opcode_reg)
      OP_READ_CHIP_STATE: expect_len = LEN_CHIP_STATE;
      OP_READ_RX_BUFFER_INFO: expect_len = LEN_RX_BUFFER_INFO;
      OP_READ_PACKET_QUALITY: expect_len = LEN_PACKET_QUALITY;
      OP_READ_INSTANT_STRENGTH: expect_len = LEN_INSTANT_STRENGTH;
      OP_READ_PACKET_COUNTERS: expect_len = LEN_PACKET_COUNTERS;
      OP_CLEAR_PACKET_COUNTERS: expect_len = LEN_CLEAR_PACKET_COUNTERS;
      OP_READ_ERROR_FLAGS: expect_len = LEN_READ_ERROR_FLAGS;
      OP_CLEAR_ERROR_FLAGS: expect_len = LEN_CLEAR_ERROR_FLAGS;
      default: known_op = 1'b0;
    endcase
  end
  logic frame_ok;
  logic bad_frame;
  // empty frames are ignored, not flagged
  assign frame_ok = frame_end && known_op && sys_count_reg == expect_len; // RL21
  assign bad_frame = frame_end && sys_count_reg != 4'h0 && !frame_ok; // RL3
  logic do_clear_counters;
  logic do_clear_errors;
  // clear commands need zero parameters, otherwise the frame is rejected
  assign do_clear_counters = frame_ok && opcode_reg == OP_CLEAR_PACKET_COUNTERS
                             && !nonzero_param_reg; // RL17
  assign do_clear_errors = frame_ok && opcode_reg == OP_CLEAR_ERROR_FLAGS
                           && !nonzero_param_reg; // RL20
  logic bad_param;
  assign bad_param = frame_ok && nonzero_param_reg && (opcode_reg == OP_CLEAR_PACKET_COUNTERS
                     || opcode_reg == OP_CLEAR_ERROR_FLAGS);

  // frame watchdog
  logic [$clog2(TIMEOUT_CYCLES + 1) - 1:0] wd_count_reg;
  logic wd_fired_reg;
  logic wd_fire;
  assign wd_fire = frame_active && watchdog_enable && !wd_fired_reg
                   && wd_count_reg == ($bits(wd_count_reg))'(TIMEOUT_CYCLES - 1);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_count_reg <= '0;
      wd_fired_reg <= 1'b0;
    end else if (!frame_active) begin
      wd_count_reg <= '0;
      wd_fired_reg <= 1'b0;
    end else if (wd_fire) begin
      wd_fired_reg <= 1'b1; // RL2
    end else if (!wd_fired_reg) begin
      wd_count_reg <= wd_count_reg + 1'b1;
    end
  end

  // command status, latest event wins; frame results override modem events
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      command_status <= CST_NONE;
    end else if (wd_fire) begin
      command_status <= CST_CMD_TIMEOUT; // RL2
    end else if (bad_frame || bad_param) begin
      command_status <= CST_PROCESSING_ERROR; // RL3
    end else if (events.exec_fail) begin
      command_status <= CST_EXEC_FAILURE; // RL4
    end else if (events.packet_done && !events.crc_fail && !events.length_fail
                 && !events.header_fail) begin
      command_status <= CST_DATA_AVAILABLE; // RL5
    end else if (events.tx_done) begin
      command_status <= CST_TX_DONE; // RL6
    end
  end

  // bit 7 and bit 0 reserved, read as zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[STATUS_MODE_LSB +: 3] = chip_mode; // RL23
    status_byte[STATUS_CMD_LSB +: 3] = command_status; // RL23
  end

  // busy while a frame is being handled and one cycle after, to finish the action
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b1;
    end else begin
      busy <= frame_active | frame_sync_reg; // RL22
    end
  end

  // measurements latched at their events
  logic [7:0] sync_strength_reg;
  logic [7:0] avg_strength_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_strength_reg <= 8'h00;
      avg_strength_reg <= 8'h00;
    end else begin
      if (sync_detect) begin
        sync_strength_reg <= packet_info.sync_time_strength; // RL11
      end
      if (events.packet_done) begin
        avg_strength_reg <= packet_info.payload_average_strength; // RL12
      end
    end
  end

  // statistics; a clear and an event in one cycle leaves the event counted
  logic [15:0] received_packet_count;
  logic [15:0] crc_fail_count;
  logic [15:0] length_fail_count;
  logic third_fail;
  assign third_fail = chirp_packet_type ? events.header_fail : events.length_fail;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      received_packet_count <= COUNTER_RESET;
      crc_fail_count <= COUNTER_RESET;
      length_fail_count <= COUNTER_RESET;
    end else begin
      received_packet_count <= (do_clear_counters ? COUNTER_RESET : received_packet_count)
                               + {15'h0000, events.packet_done}; // RL25
      crc_fail_count <= (do_clear_counters ? COUNTER_RESET : crc_fail_count)
                        + {15'h0000, events.crc_fail}; // RL25
      length_fail_count <= (do_clear_counters ? COUNTER_RESET : length_fail_count)
                           + {15'h0000, third_fail}; // RL16
    end
  end

  // error flags are sticky; a new failure in the clear cycle survives
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      device_error_word <= 16'h0000;
    end else begin
      device_error_word <= ((do_clear_errors ? 16'h0000 : device_error_word)
                            | error_set) & ERROR_WORD_USED_MASK; // RL19
    end
  end

  // response snapshot, taken while select is high and frozen during the frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      snap_reg <= 64'h0;
    end else if (!frame_active && !frame_sync_reg) begin
      snap_reg <= {received_packet_count, crc_fail_count, length_fail_count, 16'h0000};
    end
  end

  // per-opcode view is selected on the link side from separate registered snapshots
  logic [63:0] view_buffer;
  logic [63:0] view_quality;
  logic [63:0] view_strength;
  logic [63:0] view_errors;
  assign view_buffer = {packet_info.last_payload_length, packet_info.payload_start_offset,
                        48'h0}; // RL8
  assign view_quality = chirp_packet_type ?
    {packet_info.chirp_packet_strength, packet_info.chirp_packet_snr,
     packet_info.despread_signal_strength, 40'h0} : // RL14
    {packet_info.fsk_receive_flags, sync_strength_reg, avg_strength_reg, 40'h0}; // RL9
  assign view_strength = {instant_strength, 56'h0}; // RL15
  assign view_errors = {device_error_word, 48'h0}; // RL18
  logic [63:0] view_buffer_reg;
  logic [63:0] view_quality_reg;
  logic [63:0] view_strength_reg;
  logic [63:0] view_errors_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      view_buffer_reg <= 64'h0;
      view_quality_reg <= 64'h0;
      view_strength_reg <= 64'h0;
      view_errors_reg <= 64'h0;
    end else if (!frame_active && !frame_sync_reg) begin
      view_buffer_reg <= view_buffer;
      view_quality_reg <= view_quality; // RL10
      view_strength_reg <= view_strength;
      view_errors_reg <= view_errors;
    end
  end

  always_comb begin
    unique case (link_opcode_reg)
      OP_READ_RX_BUFFER_INFO: link_view = view_buffer_reg;
      OP_READ_PACKET_QUALITY: link_view = view_quality_reg; // RL13
      OP_READ_INSTANT_STRENGTH: link_view = view_strength_reg;
      OP_READ_ERROR_FLAGS: link_view = view_errors_reg;
      default: link_view = snap_reg; // RL16
    endcase
  end

  a_clear_counters: assert property (@(posedge clk_sys) disable iff (!rst_n)
    do_clear_counters && !events.packet_done |=> received_packet_count == 16'h0000) // RL17
    else $error("counters not cleared");
  a_clear_errors: assert property (@(posedge clk_sys) disable iff (!rst_n)
    do_clear_errors && error_set == 16'h0000 |=> device_error_word == 16'h0000) // RL20
    else $error("error flags not cleared");
  a_reserved_errors: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (device_error_word & ~ERROR_WORD_USED_MASK) == 16'h0000) // RL19
    else $error("reserved error bit set");
  a_timeout_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wd_fire |=> command_status == CST_CMD_TIMEOUT) // RL2
    else $error("timeout not reported");
  a_bad_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bad_frame && !wd_fire |=> command_status == CST_PROCESSING_ERROR) // RL3
    else $error("processing error not reported");
  a_exec_fail: assert property (@(posedge clk_sys) disable iff (!rst_n)
    events.exec_fail && !wd_fire && !bad_frame && !bad_param
    |=> command_status == CST_EXEC_FAILURE) // RL4
    else $error("exec failure not reported");
  a_busy_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_active |=> busy) // RL22
    else $error("busy low during frame");
  a_status_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
    status_byte[STATUS_CMD_LSB +: 3] == command_status && !status_byte[7]
    && !status_byte[0]) // RL23
    else $error("status byte malformed");
  a_sync_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sync_detect |=> sync_strength_reg == $past(packet_info.sync_time_strength)) // RL11
    else $error("sync strength not latched");
endmodule : rsq_status_query
`default_nettype wire

/* File: testbench/rsq_host_model.sv */
// host side spi master model, mode 0, clock runs only within frames
`timescale 1ns/1ps
`default_nettype none
module rsq_host_model (
  // spi master pins
  output logic spi_sck,
  output logic chip_select_n,
  output logic spi_mosi,
  // device data
  input wire logic spi_miso
);
  initial begin
    spi_sck = 1'b0;
    chip_select_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // bytes msb first in tx, opcode in the top byte
  task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    chip_select_n = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      spi_mosi = tx[63-i];
      #40 spi_sck = 1'b1;
      rx[63-i] = spi_miso;
      #40 spi_sck = 1'b0;
    end
    #40 chip_select_n = 1'b1;
    // line left floating: show the inverse, not a stale copy
    spi_mosi = ~spi_mosi;
  endtask : xfer
endmodule : rsq_host_model
`default_nettype wire

/* File: testbench/rsq_status_query_test.sv */
// self-checking bench for the status query command block
`timescale 1ns/1ps
`default_nettype none
module rsq_status_query_test;
  import rsq_pkg::*;
  logic clk_sys, resetn, spi_sck, chip_select_n, spi_mosi, spi_miso, busy;
  logic watchdog_enable, chirp_packet_type, sync_detect;
  rsq_mode_type chip_mode;
  rsq_packet_info_type packet_info;
  rsq_events_type events;
  logic [7:0] instant_strength;
  logic [15:0] error_set, device_error_word;
  logic [2:0] command_status;
  logic [63:0] rx;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  rsq_status_query #(.TIMEOUT_CYCLES(50)) i_rsq_status_query (.clk_sys(clk_sys),
    .resetn(resetn), .spi_sck(spi_sck), .chip_select_n(chip_select_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .busy(busy), .watchdog_enable(watchdog_enable),
    .chirp_packet_type(chirp_packet_type), .chip_mode(chip_mode), .packet_info(packet_info),
    .sync_detect(sync_detect), .instant_strength(instant_strength), .events(events),
    .error_set(error_set), .device_error_word(device_error_word),
    .command_status(command_status));
  rsq_host_model i_rsq_host_model (.spi_sck(spi_sck), .chip_select_n(chip_select_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task final_report;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // hang guard, far above the roughly 1300 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      final_report();
    end
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] by(input int i);
    return rx[63-8*i -: 8];
  endfunction : by
  function automatic logic [7:0] st(input logic [2:0] c);
    return {1'b0, chip_mode, c, 1'b0};
  endfunction : st
  task wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    if (busy !== 1'b0) begin
      n_fail++;
      $display("[FAIL] busy expected 0 seen %b", busy);
    end
  endtask : wait_idle
  task fr(input int n, input logic [63:0] tx);
    wait_idle();
    i_rsq_host_model.xfer(n, tx, rx);
    chk("busy in frame", 16'h0001, busy);
    repeat (2) @(negedge clk_sys);
    wait_idle();
    repeat (6) @(negedge clk_sys);
  endtask : fr
  task ev(input logic [5:0] e);
    @(negedge clk_sys);
    events = e;
    @(negedge clk_sys);
    events = '0;
    repeat (4) @(negedge clk_sys);
  endtask : ev
  task t_events;
    fr(2, 64'hc000_0000_0000_0000);
    chk("idle status", st(CST_NONE), by(1));
    ev(6'h20);
    chk("data avail", CST_DATA_AVAILABLE, command_status);
    fr(4, 64'h1300_0000_0000_0000);
    chk("status on cmd", st(CST_DATA_AVAILABLE), by(1));
    ev(6'h02);
    chk("tx done", CST_TX_DONE, command_status);
    ev(6'h01);
    chk("exec fail", CST_EXEC_FAILURE, command_status);
    fr(2, 64'h5500_0000_0000_0000);
    chk("bad opcode", CST_PROCESSING_ERROR, command_status);
    ev(6'h02);
    fr(5, 64'h1500_0000_0000_0000);
    chk("bad length", CST_PROCESSING_ERROR, command_status);
  endtask : t_events
  task t_fields;
    packet_info = 64'h2180_125a_6470_f47c;
    sync_detect = 1'b1;
    @(negedge clk_sys);
    sync_detect = 1'b0;
    ev(6'h20);
    packet_info = 64'h2180_1200_0070_f47c;
    fr(4, 64'h1300_0000_0000_0000);
    chk("length/offset", 16'h2180, {by(2), by(3)});
    fr(5, 64'h1400_0000_0000_0000);
    chk("fsk quality", 16'h125a, {by(2), by(3)});
    chk("fsk average", 16'h0064, by(4));
    chirp_packet_type = 1'b1;
    fr(5, 64'h1400_0000_0000_0000);
    chk("chirp quality", 16'h70f4, {by(2), by(3)});
    chk("despread", 16'h007c, by(4));
    fr(3, 64'h1500_0000_0000_0000);
    chk("instant", 16'h00b3, by(2));
    chirp_packet_type = 1'b0;
  endtask : t_fields
  task t_counters;
    fr(7, 64'h0);
    ev(6'h30);
    ev(6'h28);
    fr(8, 64'h1000_0000_0000_0000);
    chk("received", 16'h0002, {by(2), by(3)});
    chk("crc fails", 16'h0001, {by(4), by(5)});
    chk("length fails", 16'h0001, {by(6), by(7)});
    fr(7, 64'h0001_0000_0000_0000);
    chk("nonzero clear", CST_PROCESSING_ERROR, command_status);
    fr(7, 64'h0);
    fr(8, 64'h1000_0000_0000_0000);
    chk("cleared", 16'h0000, {by(2), by(3)} | {by(4), by(5)} | {by(6), by(7)});
  endtask : t_counters
  task t_errors;
    @(negedge clk_sys);
    error_set = 16'hffff;
    @(negedge clk_sys);
    error_set = '0;
    chk("error word", 16'h017f, device_error_word);
    fr(4, 64'h1700_0000_0000_0000);
    chk("error frame", 16'h017f, {by(2), by(3)});
    fr(3, 64'h0700_0000_0000_0000);
    chk("clear status", st(CST_PROCESSING_ERROR), by(2));
    chk("errors cleared", 16'h0000, device_error_word);
    watchdog_enable = 1'b1;
    fr(8, 64'h1000_0000_0000_0000);
    chk("timeout", CST_CMD_TIMEOUT, command_status);
    watchdog_enable = 1'b0;
  endtask : t_errors
  initial begin
    resetn = 1'b0;
    watchdog_enable = 1'b0;
    chirp_packet_type = 1'b0;
    chip_mode = RSQ_MODE_STANDBY_RC;
    packet_info = '0;
    sync_detect = 1'b0;
    instant_strength = 8'hb3;
    events = '0;
    error_set = '0;
    repeat (6) @(negedge clk_sys);
    chk("busy in reset", 16'h0001, busy);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_events();
    t_fields();
    t_counters();
    t_errors();
    final_report();
  end
endmodule : rsq_status_query_test
`default_nettype wire
